/* File: include/pieb_defines.vh */
`ifndef PIEB_DEFINES_VH
`define PIEB_DEFINES_VH

// ------------------------------------------------------------------
// Register offsets (byte addresses on the register port)
// ------------------------------------------------------------------
`define PIEB_ADDR_W          12
`define PIEB_OFF_ENABLE_3    12'h099
`define PIEB_OFF_ENABLE_4    12'h09A
`define PIEB_OFF_FLAG_3      12'h08F
`define PIEB_OFF_FLAG_4      12'h090
`define PIEB_OFF_INT_CTRL    12'h00B

// ------------------------------------------------------------------
// Field positions
// ------------------------------------------------------------------
`define PIEB_E3_SERIAL1_TX   2
`define PIEB_E3_LOGIC_CELL4  1
`define PIEB_E3_LOGIC_CELL3  0
`define PIEB_E4_ZERO_CROSS   5
`define PIEB_E4_CONV_THRESH  4
`define PIEB_E4_CONV_DONE    3
`define PIEB_E4_COMPARATOR1  2
`define PIEB_E4_SSP2_COLL    1
`define PIEB_E4_SSP2         0
`define PIEB_CTRL_GLOBAL     7
`define PIEB_CTRL_PERIPH     6

// ------------------------------------------------------------------
// Implemented bit masks and reset values
// ------------------------------------------------------------------
`define PIEB_MASK_3          8'h07
`define PIEB_MASK_4          8'h3F
`define PIEB_MASK_CTRL       8'hC0
`define PIEB_RESET_VAL       8'h00

`endif

/* File: hw/pieb_enable_reg.v */
`timescale 1ns/100ps
`default_nettype none
`include "pieb_defines.vh"

// Enable register: only masked bits are stored, others read zero
module pieb_enable_reg #(
    parameter [7:0] MASK = 8'hFF
) (
    input  wire       mclk,    // System clock
    input  wire       rst,     // Async reset, active high
    input  wire       wr_en,   // Write strobe for this register
    input  wire [7:0] wdata,   // Write data
    output reg  [7:0] value    // Stored enable bits
);

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    // Unimplemented positions never load, so they stay zero
    always @(posedge mclk or posedge rst)
    begin
        if (rst)
            value <= `PIEB_RESET_VAL;
        else if (wr_en)
            value <= wdata & MASK;
    end

endmodule // pieb_enable_reg
`default_nettype wire

/* File: hw/pieb_flag_reg.v */
`timescale 1ns/100ps
`default_nettype none
`include "pieb_defines.vh"

// Sticky flag register: hardware set wins over software clear
module pieb_flag_reg #(
    parameter [7:0] MASK = 8'hFF
) (
    input  wire       mclk,    // System clock
    input  wire       rst,     // Async reset, active high
    input  wire [7:0] set,     // Event pulses from sources
    input  wire       wr_en,   // Software write strobe
    input  wire [7:0] wdata,   // Write data, zero bits clear
    output reg  [7:0] value    // Current flags
);

    // ------------------------------------------------------------------
    // Flag update
    // ------------------------------------------------------------------
    // Set is ORed after the write so an event in a clearing cycle survives
    always @(posedge mclk or posedge rst)
    begin
        if (rst)
            value <= `PIEB_RESET_VAL;
        else if (wr_en)
            value <= ((wdata & value) | set) & MASK;
        else
            value <= (value | set) & MASK;
    end

endmodule // pieb_flag_reg
`default_nettype wire

/* File: hw/pieb_bank.v */
// Notes on behaviour
// [R1] Enable 3 bit 2 passes the serial port 1 transmit request when 1, blocks it when 0.
// [R2] Enable 3 bit 1 passes the logic cell 4 request when 1, blocks it when 0.
// [R3] Enable 3 bit 0 passes the logic cell 3 request when 1, blocks it when 0.
// [R4] Enable 4 sits at 0x009A with read-write bits 5..0 that clear on reset.
// [R5] Enable 4 bit 5 passes the zero-cross request when 1, blocks it when 0.
// [R6] Enable 4 bit 4 passes the converter threshold request when 1, blocks it when 0.
// [R7] Enable 4 bit 3 passes the conversion done request when 1, blocks it when 0.
// [R8] Enable 4 bit 2 passes the comparator 1 request when 1, blocks it when 0.
// [R9] Enable 4 bit 1 passes the serial port 2 collision request when 1, blocks it when 0.
// [R10] Enable 4 bit 0 passes the serial port 2 request when 1, blocks it when 0.
// [R11] No source here interrupts unless the shared peripheral enable is also set.
// [R12] Flags set on their event regardless of any enable; enables gate only the request.
// [R13] Enable 4 bits 7 and 6 ignore writes and read as zero.
`timescale 1ns/100ps
`default_nettype none
`include "pieb_defines.vh"

module pieb_bank (
    input  wire        mclk,           // System clock, 20 MHz
    input  wire        rst,            // Async reset, active high
    input  wire [11:0] addr,           // Register byte address
    input  wire [7:0]  wdata,          // Write data
    input  wire        wr,             // Write strobe
    input  wire        rd,             // Read strobe
    output reg  [7:0]  rdata,          // Read data, cycle after rd
    input  wire [2:0]  src_event_3,    // Events: serial1 tx, cell4, cell3
    input  wire [5:0]  src_event_4,    // Events: zcd, thresh, done, cmp1, coll, ssp2
    output wire [7:0]  gated_req,      // Requests after own enable; bit 2 merges done and cmp1
    output wire        periph_req,     // Combined peripheral request
    output wire        irq             // Request qualified by global enable
);

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    function hit;
        input [11:0] a;
        input [11:0] off;
        begin
            hit = (a == off);
        end
    endfunction

    wire wr_en3  = wr & hit(addr, `PIEB_OFF_ENABLE_3);
    wire wr_en4  = wr & hit(addr, `PIEB_OFF_ENABLE_4);
    wire wr_fl3  = wr & hit(addr, `PIEB_OFF_FLAG_3);
    wire wr_fl4  = wr & hit(addr, `PIEB_OFF_FLAG_4);
    wire wr_ctl  = wr & hit(addr, `PIEB_OFF_INT_CTRL);

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    wire [7:0] periph_irq_enable_3;
    wire [7:0] periph_irq_enable_4;
    wire [7:0] flags_3;
    wire [7:0] flags_4;
    reg  [7:0] interrupt_control_reg;

    pieb_enable_reg #(.MASK(`PIEB_MASK_3)) u_en3 (
        .mclk  (mclk),
        .rst   (rst),
        .wr_en (wr_en3),
        .wdata (wdata),
        .value (periph_irq_enable_3)
    );

    // Only bits 5..0 stored; 7..6 read zero
    pieb_enable_reg #(.MASK(`PIEB_MASK_4)) u_en4 ( // R4 R13
        .mclk  (mclk),
        .rst   (rst),
        .wr_en (wr_en4),
        .wdata (wdata),
        .value (periph_irq_enable_4)
    );

    // Flags latch events whatever the enables say
    pieb_flag_reg #(.MASK(`PIEB_MASK_3)) u_fl3 ( // R12
        .mclk  (mclk),
        .rst   (rst),
        .set   ({5'h00, src_event_3}),
        .wr_en (wr_fl3),
        .wdata (wdata),
        .value (flags_3)
    );

    pieb_flag_reg #(.MASK(`PIEB_MASK_4)) u_fl4 ( // R12
        .mclk  (mclk),
        .rst   (rst),
        .set   ({2'h0, src_event_4}),
        .wr_en (wr_fl4),
        .wdata (wdata),
        .value (flags_4)
    );

    // Interrupt control: global and shared peripheral enables
    always @(posedge mclk or posedge rst)
    begin
        if (rst)
            interrupt_control_reg <= `PIEB_RESET_VAL;
        else if (wr_ctl)
            interrupt_control_reg <= wdata & `PIEB_MASK_CTRL;
    end

    wire global_int_en            = interrupt_control_reg[`PIEB_CTRL_GLOBAL];
    wire peripheral_int_global_en = interrupt_control_reg[`PIEB_CTRL_PERIPH];

    // ------------------------------------------------------------------
    // Request gating
    // ------------------------------------------------------------------
    wire serial1_transmit_int_en       = periph_irq_enable_3[`PIEB_E3_SERIAL1_TX];
    wire logic_cell4_int_en            = periph_irq_enable_3[`PIEB_E3_LOGIC_CELL4];
    wire logic_cell3_int_en            = periph_irq_enable_3[`PIEB_E3_LOGIC_CELL3];
    wire zero_cross_int_en             = periph_irq_enable_4[`PIEB_E4_ZERO_CROSS];
    wire converter_threshold_int_en    = periph_irq_enable_4[`PIEB_E4_CONV_THRESH];
    wire conversion_done_int_en        = periph_irq_enable_4[`PIEB_E4_CONV_DONE];
    wire comparator1_int_en            = periph_irq_enable_4[`PIEB_E4_COMPARATOR1];
    wire sync_serial2_collision_int_en = periph_irq_enable_4[`PIEB_E4_SSP2_COLL];
    wire sync_serial2_int_en           = periph_irq_enable_4[`PIEB_E4_SSP2];

    // Gating is combinational so a cleared enable blocks at once
    assign gated_req[7] = flags_3[`PIEB_E3_SERIAL1_TX] & serial1_transmit_int_en;      // R1
    assign gated_req[6] = flags_3[`PIEB_E3_LOGIC_CELL4] & logic_cell4_int_en;          // R2
    assign gated_req[5] = flags_3[`PIEB_E3_LOGIC_CELL3] & logic_cell3_int_en;          // R3
    assign gated_req[4] = flags_4[`PIEB_E4_ZERO_CROSS] & zero_cross_int_en;            // R5
    assign gated_req[3] = flags_4[`PIEB_E4_CONV_THRESH] & converter_threshold_int_en;  // R6
    assign gated_req[2] = (flags_4[`PIEB_E4_CONV_DONE] & conversion_done_int_en)       // R7
                        | (flags_4[`PIEB_E4_COMPARATOR1] & comparator1_int_en);        // R8
    assign gated_req[1] = flags_4[`PIEB_E4_SSP2_COLL] & sync_serial2_collision_int_en; // R9
    assign gated_req[0] = flags_4[`PIEB_E4_SSP2] & sync_serial2_int_en;                // R10

    // Shared peripheral enable qualifies every source here
    assign periph_req = (|gated_req) & peripheral_int_global_en; // R11
    assign irq        = periph_req & global_int_en;

    // ------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------
    // Unmapped addresses read zero; data only valid the cycle after rd
    always @(posedge mclk or posedge rst)
    begin
        if (rst)
            rdata <= `PIEB_RESET_VAL;
        else if (rd)
        begin
            if (hit(addr, `PIEB_OFF_ENABLE_3))
                rdata <= periph_irq_enable_3;
            else if (hit(addr, `PIEB_OFF_ENABLE_4))
                rdata <= periph_irq_enable_4; // R13
            else if (hit(addr, `PIEB_OFF_FLAG_3))
                rdata <= flags_3;
            else if (hit(addr, `PIEB_OFF_FLAG_4))
                rdata <= flags_4;
            else if (hit(addr, `PIEB_OFF_INT_CTRL))
                rdata <= interrupt_control_reg;
            else
                rdata <= `PIEB_RESET_VAL;
        end
        else
            rdata <= `PIEB_RESET_VAL;
    end

endmodule // pieb_bank
`default_nettype wire

/* File: bench/pieb_bank_monitor.sv */
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------
// Port-level checks of the enable bank
// ----------------------------------------------------------------
module pieb_bank_monitor (
    input wire logic        mclk,        // System clock
    input wire logic        rst,         // Async reset
    input wire logic [11:0] addr,        // Register address
    input wire logic [7:0]  wdata,       // Write data
    input wire logic        wr,          // Write strobe
    input wire logic        rd,          // Read strobe
    input wire logic [7:0]  rdata,       // Read data
    input wire logic [2:0]  src_event_3, // Events, bank 3
    input wire logic [5:0]  src_event_4, // Events, bank 4
    input wire logic [7:0]  gated_req,   // Gated requests
    input wire logic        periph_req,  // Peripheral request
    input wire logic        irq          // Qualified request
);
    logic [7:0] en3;
    logic [7:0] en4;
    logic [7:0] ctl;
    logic [7:0] allowed;
    logic [7:0] ev_map;

    // Shadows built from port writes only, so a dead register shows up
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            {en3, en4, ctl} <= 24'h000000;
        else if (wr && addr == 12'h099)
            en3 <= wdata & 8'h07;
        else if (wr && addr == 12'h09A)
            en4 <= wdata & 8'h3F;
        else if (wr && addr == 12'h00B)
            ctl <= wdata & 8'hC0;
    end

    // Two sources share request bit 2, hence the merged terms
    assign allowed = {en3[2:0], en4[5:4], en4[3] | en4[2], en4[1:0]};
    assign ev_map  = {src_event_3, src_event_4[5:4], src_event_4[3] | src_event_4[2],
                      src_event_4[1:0]};

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    rdata_idle_a: assert property (!rd |=> rdata == 8'h00)
        else $error("read data not zero outside a read");
    en3_read_a: assert property (rd && addr == 12'h099 |=> rdata == $past(en3))
        else $error("enable 3 read back wrong");
    en4_read_a: assert property (rd && addr == 12'h09A |=> rdata == $past(en4))
        else $error("enable 4 read back wrong");
    unmapped_read_a: assert property (rd && !(addr inside {12'h099, 12'h09A, 12'h08F,
        12'h090, 12'h00B}) |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    reset_clear_a: assert property ($fell(rst) |-> gated_req == 8'h00 && !irq)
        else $error("requests present after reset");
    enable_gate_a: assert property ((gated_req & ~allowed) == 8'h00)
        else $error("request passed a cleared enable");
    event_pass_a: assert property (|ev_map |=> (($past(ev_map) & allowed & ~gated_req) & 8'hFB) == 8'h00
        && (gated_req[2] || !(($past(src_event_4[3]) && en4[3]) || ($past(src_event_4[2]) && en4[2]))))
        else $error("enabled event gave no request");
    periph_gate_a: assert property (periph_req == ((|gated_req) && ctl[6]))
        else $error("peripheral request ignores its enable");
    global_gate_a: assert property (irq == (periph_req && ctl[7]))
        else $error("interrupt ignores global enable");
endmodule // pieb_bank_monitor

bind pieb_bank pieb_bank_monitor u_mon (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .src_event_3(src_event_3), .src_event_4(src_event_4),
    .gated_req(gated_req), .periph_req(periph_req), .irq(irq));

`default_nettype wire

/* File: bench/pieb_bank_test.sv */
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------
// Register-level test of the enable bank
// ----------------------------------------------------------------
module pieb_bank_test;
    logic        mclk, rst, wr, rd, periph_req, irq;
    logic [11:0] addr, fa, ea;
    logic [7:0]  wdata, rdata, gated_req, bm;
    logic [8:0]  ev;
    int          miscompares, tests_run, s, gb;

    pieb_bank DUT (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .src_event_3(ev[8:6]), .src_event_4(ev[5:0]),
        .gated_req(gated_req), .periph_req(periph_req), .irq(irq));

    initial
    begin
        mclk = 1'h0;
        forever #25 mclk = ~mclk;
    end

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Strobes last one cycle; the #1 lets the write land before any check
    task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
        @(posedge mclk);
        wr <= 1'h1;
        addr <= a;
        wdata <= d;
        @(posedge mclk);
        wr <= 1'h0;
        #1;
    endtask

    task automatic rd_reg(input logic [11:0] a, input logic [7:0] exp, input string name);
        @(posedge mclk);
        rd <= 1'h1;
        addr <= a;
        @(posedge mclk);
        rd <= 1'h0;
        #1 check(name, rdata, exp);
    endtask

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Guard against a hung sequence
    initial
    begin
        repeat (20000) @(posedge mclk);
        miscompares++;
        test_done();
    end

    initial
    begin
        rst = 1'h1;
        {wr, rd, addr, wdata, ev} = '0;
        repeat (6) @(posedge mclk);
        rst <= 1'h0;
        rd_reg(12'h09A, 8'h00, "enable4 reset");
        wr_reg(12'h09A, 8'hFF);
        rd_reg(12'h09A, 8'h3F, "enable4 mask");
        wr_reg(12'h099, 8'hFF);
        rd_reg(12'h099, 8'h07, "enable3 mask");
        wr_reg(12'h123, 8'hFF);
        rd_reg(12'h123, 8'h00, "unmapped read");
        // A reset in mid-run must drop the enables again
        @(posedge mclk);
        rst <= 1'h1;
        repeat (2) @(posedge mclk);
        rst <= 1'h0;
        rd_reg(12'h09A, 8'h00, "enable4 after reset");
        // Each source: flagged but blocked, then passed, then held by the shared enables
        for (s = 0; s < 9; s++)
        begin
            fa = s > 5 ? 12'h08F : 12'h090;
            ea = s > 5 ? 12'h099 : 12'h09A;
            bm = 8'h01 << (s > 5 ? s - 6 : s);
            gb = s > 3 ? s - 1 : (s > 1 ? 2 : s);
            wr_reg(12'h00B, 8'hC0);
            @(posedge mclk);
            ev <= 9'h001 << s;
            @(posedge mclk);
            ev <= 9'h000;
            #1 check("blocked request", {gated_req[7:1], irq}, 8'h00);
            rd_reg(fa, bm, "flag");
            wr_reg(ea, bm);
            check("passed request", gated_req, 8'h01 << gb);
            check("both enables", {6'h00, periph_req, irq}, 8'h03);
            wr_reg(12'h00B, 8'h80);
            check("periph enable off", {6'h00, periph_req, irq}, 8'h00);
            wr_reg(12'h00B, 8'h40);
            check("global enable off", {6'h00, periph_req, irq}, 8'h02);
            wr_reg(fa, 8'h00);
            wr_reg(ea, 8'h00);
        end
        test_done();
    end
endmodule // pieb_bank_test

`default_nettype wire
